// ==== src/dtc_pkg.sv ====
// Package: register map, field layouts and timing of the dual timer block
package dtc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_TCTL   = 8'h88;
    localparam logic [7:0] ADDR_TMODE  = 8'h89;
    localparam logic [7:0] ADDR_TL0    = 8'h8a;
    localparam logic [7:0] ADDR_TL1    = 8'h8b;
    localparam logic [7:0] ADDR_TH0    = 8'h8c;
    localparam logic [7:0] ADDR_TH1    = 8'h8d;
    localparam logic [7:0] ADDR_ISTAT  = 8'ha0;
    localparam logic [7:0] ADDR_IMASK  = 8'ha1;
    // Reset values
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [3:0] RST_EVT     = 4'h0;
    // Mode codes
    localparam logic [1:0] MODE_PRE13  = 2'h0;
    localparam logic [1:0] MODE_CNT16  = 2'h1;
    localparam logic [1:0] MODE_RELD8  = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;
    // Event bit positions in status and mask
    localparam int EVT_IRQ0 = 0;
    localparam int EVT_IRQ1 = 1;
    localparam int EVT_OVF0 = 2;
    localparam int EVT_OVF1 = 3;
    // Timing: 20 MHz clock, one machine cycle is 600 ns
    localparam int CLK_PERIOD_NS = 50;
    localparam int MCYCLE_NS     = 600;
    localparam int MCYCLE_CLKS   = MCYCLE_NS / CLK_PERIOD_NS;

    // Layout of timer_run_and_irq_flags, bit 7 down to bit 0
    typedef struct packed {
        logic overflow_flag_one;
        logic run_bit_one;
        logic overflow_flag_zero;
        logic run_bit_zero;
        logic ext_irq_flag_one;
        logic ext_irq_type_one;
        logic ext_irq_flag_zero;
        logic ext_irq_type_zero;
    } dtc_tctl_t;

    // Half of timer_mode_control for one timer
    typedef struct packed {
        logic       gate;
        logic       count_sel;
        logic [1:0] mode;
    } dtc_tcfg_t;

    typedef struct packed {
        dtc_tcfg_t one;
        dtc_tcfg_t zero;
    } dtc_tmode_t;

    // External pins, all asynchronous to i_clock
    typedef struct packed {
        logic count_input_one;
        logic count_input_zero;
        logic ext_irq_pin_one;
        logic ext_irq_pin_zero;
    } dtc_pins_t;

    // Service-entry strobes from the interrupt controller
    typedef struct packed {
        logic ovf_one;
        logic ovf_zero;
        logic irq_one;
        logic irq_zero;
    } dtc_ack_t;
endpackage : dtc_pkg

// ==== src/dtc_timer.sv ====
// Two classic-style timer/counters with external interrupt flag logic
//
// Functional notes
// R1: Timer one overflow sets its flag; service entry clears; software writes.
// R2: Timer zero overflow sets its flag; service entry clears; software writes.
// R3: Timer one counts only with run bit, and pin one high when gated.
// R4: Timer zero counts only with run bit, and pin zero high when gated.
// R5: Irq one flag set by fall or low; edge clears on service, level tracks.
// R6: Irq zero flag set by fall or low; edge clears on service, level tracks.
// R7: Irq one type bit: one selects falling edge, zero selects low level.
// R8: Irq zero type bit: one selects falling edge, zero selects low level.
// R9: Timer one counts machine cycles, or falling edges of its count pin.
// R10: Timer zero counts machine cycles, or falling edges of its count pin.
// R11: Mode fields at bits 5:4 and 1:0; mode 0 uses 5-bit prescaler.
// R12: Mode 1 is a plain 16-bit counter of high and low byte.
// R13: Mode 2 counts low byte, reloading it from high byte on overflow.
// R14: Mode 3 splits timer zero: low byte own controls, high byte timer one's.
// R15: Timer one in mode 3 stops and holds its value.
// R16: All four count bytes are readable and writable registers.
// R17: In mode 3 timer zero high byte overflow sets timer one flag.
// R18: Pins synchronised, sampled per machine cycle; fall is high then low.
// R19: External sources hold each pin level at least one machine cycle.
`timescale 1ns/1ns
module dtc_timer #(
    parameter int MCYC_CLKS = dtc_pkg::MCYCLE_CLKS
) (
    input  wire logic              i_clock,
    input  wire logic              i_nrst,
    input  wire logic [7:0]        i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    input  wire dtc_pkg::dtc_pins_t i_pins,
    input  wire dtc_pkg::dtc_ack_t  i_ack,
    output logic [7:0]             o_rdata,
    output dtc_pkg::dtc_tctl_t     o_tctl,
    output logic                   o_irq
);
    import dtc_pkg::*;

    if (MCYC_CLKS < 2 || MCYC_CLKS > 255) begin : g_chk
        $error("MCYC_CLKS must lie in 2..255");
    end

    ////////////////////////////////////////////////////////////////////////
    // Machine-cycle enable
    logic [7:0] div_r;
    logic       mcyc;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            div_r <= 8'h00;
        end else if (div_r == 8'(MCYC_CLKS - 1)) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    assign mcyc = (div_r == 8'(MCYC_CLKS - 1));

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and per-machine-cycle sampling
    dtc_pins_t pin_s1_r;
    dtc_pins_t pin_s2_r;
    dtc_pins_t smp_r;
    dtc_pins_t fall;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_s1_r <= '1;
            pin_s2_r <= '1;
        end else begin
            pin_s1_r <= i_pins;
            pin_s2_r <= pin_s1_r;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            smp_r <= '1;
        end else if (mcyc) begin
            smp_r <= pin_s2_r;                              // [R18]
        end
    end

    // Previous sample high, current sample low
    assign fall = smp_r & ~pin_s2_r;                        // [R18]

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    dtc_tctl_t  tctl_r;
    dtc_tmode_t tmode_r;
    logic [7:0] tl0_r;
    logic [7:0] th0_r;
    logic [7:0] tl1_r;
    logic [7:0] th1_r;
    logic [3:0] istat_r;
    logic [3:0] imask_r;
    logic       wr_tctl;
    logic       wr_tl0;
    logic       wr_th0;
    logic       wr_tl1;
    logic       wr_th1;

    assign wr_tctl = i_wr && (i_addr == ADDR_TCTL);
    assign wr_tl0  = i_wr && (i_addr == ADDR_TL0);
    assign wr_th0  = i_wr && (i_addr == ADDR_TH0);
    assign wr_tl1  = i_wr && (i_addr == ADDR_TL1);
    assign wr_th1  = i_wr && (i_addr == ADDR_TH1);

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tmode_r <= RST_BYTE;
        end else if (i_wr && i_addr == ADDR_TMODE) begin
            tmode_r <= i_wdata;                             // [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Count step for modes 0..2; mode 3 holds
    function automatic logic [16:0] step(input logic [1:0] m,
                                         input logic [7:0] tl,
                                         input logic [7:0] th);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0]  s8;
        s13 = {1'b0, th, tl[4:0]} + 14'h0001;
        s16 = {1'b0, th, tl} + 17'h00001;
        s8  = {1'b0, tl} + 9'h001;
        case (m)
            MODE_PRE13: step = {s13[13], s13[12:5], tl[7:5], s13[4:0]};
            MODE_CNT16: step = s16;
            MODE_RELD8: step = {s8[8], th, (s8[8] ? th : s8[7:0])};
            default:    step = {1'b0, th, tl};
        endcase
    endfunction : step

    ////////////////////////////////////////////////////////////////////////
    // Count enables
    logic        split0;
    logic        cnt0_en;
    logic        cnt1_en;
    logic        th0_split_en;
    logic [16:0] nx0;
    logic [16:0] nx1;
    logic [8:0]  tl0_s8;
    logic [8:0]  th0_s8;
    logic        ovf0;
    logic        ovf1;

    assign split0 = (tmode_r.zero.mode == MODE_SPLIT);

    assign cnt0_en = mcyc && tctl_r.run_bit_zero                 // [R4]
        && (!tmode_r.zero.gate || smp_r.ext_irq_pin_zero)        // [R4]
        && (!tmode_r.zero.count_sel || fall.count_input_zero);   // [R10]

    assign cnt1_en = mcyc && tctl_r.run_bit_one                  // [R3]
        && (!tmode_r.one.gate || smp_r.ext_irq_pin_one)          // [R3]
        && (!tmode_r.one.count_sel || fall.count_input_one)      // [R9]
        && (tmode_r.one.mode != MODE_SPLIT);                     // [R15]

    assign th0_split_en = mcyc && split0 && tctl_r.run_bit_one;  // [R17]

    assign nx0    = step(tmode_r.zero.mode, tl0_r, th0_r);
    assign nx1    = step(tmode_r.one.mode, tl1_r, th1_r);
    assign tl0_s8 = {1'b0, tl0_r} + 9'h001;
    assign th0_s8 = {1'b0, th0_r} + 9'h001;

    assign ovf0 = cnt0_en && (split0 ? tl0_s8[8] : nx0[16]);     // [R2]
    // In split mode timer one keeps counting but the flag is taken over
    assign ovf1 = split0 ? (th0_split_en && th0_s8[8])           // [R17]
                         : (cnt1_en && nx1[16]);                 // [R1]

    ////////////////////////////////////////////////////////////////////////
    // Timer zero count bytes
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tl0_r <= RST_BYTE;
        end else if (wr_tl0) begin
            tl0_r <= i_wdata;                                    // [R16]
        end else if (cnt0_en) begin
            tl0_r <= split0 ? tl0_s8[7:0] : nx0[7:0];            // [R14]
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            th0_r <= RST_BYTE;
        end else if (wr_th0) begin
            th0_r <= i_wdata;                                    // [R16]
        end else if (th0_split_en) begin
            th0_r <= th0_s8[7:0];                                // [R14]
        end else if (cnt0_en && !split0) begin
            th0_r <= nx0[15:8];                                  // [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer one count bytes
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tl1_r <= RST_BYTE;
        end else if (wr_tl1) begin
            tl1_r <= i_wdata;                                    // [R16]
        end else if (cnt1_en) begin
            tl1_r <= nx1[7:0];                                   // [R13]
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            th1_r <= RST_BYTE;
        end else if (wr_th1) begin
            th1_r <= i_wdata;                                    // [R16]
        end else if (cnt1_en) begin
            th1_r <= nx1[15:8];                                  // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and flag register; hardware set wins over any clear
    logic irq0_edge;
    logic irq1_edge;
    logic irq0_low;
    logic irq1_low;

    assign irq0_edge = mcyc && tctl_r.ext_irq_type_zero
                       && fall.ext_irq_pin_zero;                 // [R8]
    assign irq1_edge = mcyc && tctl_r.ext_irq_type_one
                       && fall.ext_irq_pin_one;                  // [R7]
    assign irq0_low  = !tctl_r.ext_irq_type_zero && !smp_r.ext_irq_pin_zero;
    assign irq1_low  = !tctl_r.ext_irq_type_one && !smp_r.ext_irq_pin_one;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tctl_r.run_bit_one       <= 1'b0;
            tctl_r.run_bit_zero      <= 1'b0;
            tctl_r.ext_irq_type_one  <= 1'b0;
            tctl_r.ext_irq_type_zero <= 1'b0;
        end else if (wr_tctl) begin
            tctl_r.run_bit_one       <= i_wdata[6];
            tctl_r.run_bit_zero      <= i_wdata[4];
            tctl_r.ext_irq_type_one  <= i_wdata[2];
            tctl_r.ext_irq_type_zero <= i_wdata[0];
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tctl_r.overflow_flag_one <= 1'b0;
        end else if (ovf1) begin
            tctl_r.overflow_flag_one <= 1'b1;                    // [R1]
        end else if (wr_tctl) begin
            tctl_r.overflow_flag_one <= i_wdata[7];              // [R1]
        end else if (i_ack.ovf_one) begin
            tctl_r.overflow_flag_one <= 1'b0;                    // [R1]
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tctl_r.overflow_flag_zero <= 1'b0;
        end else if (ovf0) begin
            tctl_r.overflow_flag_zero <= 1'b1;                   // [R2]
        end else if (wr_tctl) begin
            tctl_r.overflow_flag_zero <= i_wdata[5];             // [R2]
        end else if (i_ack.ovf_zero) begin
            tctl_r.overflow_flag_zero <= 1'b0;                   // [R2]
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tctl_r.ext_irq_flag_one <= 1'b0;
        end else if (!tctl_r.ext_irq_type_one) begin
            tctl_r.ext_irq_flag_one <= !smp_r.ext_irq_pin_one;   // [R5]
        end else if (irq1_edge) begin
            tctl_r.ext_irq_flag_one <= 1'b1;                     // [R5]
        end else if (wr_tctl) begin
            tctl_r.ext_irq_flag_one <= i_wdata[3];
        end else if (i_ack.irq_one) begin
            tctl_r.ext_irq_flag_one <= 1'b0;                     // [R5]
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tctl_r.ext_irq_flag_zero <= 1'b0;
        end else if (!tctl_r.ext_irq_type_zero) begin
            tctl_r.ext_irq_flag_zero <= !smp_r.ext_irq_pin_zero; // [R6]
        end else if (irq0_edge) begin
            tctl_r.ext_irq_flag_zero <= 1'b1;                    // [R6]
        end else if (wr_tctl) begin
            tctl_r.ext_irq_flag_zero <= i_wdata[1];
        end else if (i_ack.irq_zero) begin
            tctl_r.ext_irq_flag_zero <= 1'b0;                    // [R6]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status (write one to clear, set wins) and mask
    logic [3:0] evt;

    always_comb begin
        evt           = 4'h0;
        evt[EVT_IRQ0] = irq0_edge || irq0_low;
        evt[EVT_IRQ1] = irq1_edge || irq1_low;
        evt[EVT_OVF0] = ovf0;
        evt[EVT_OVF1] = ovf1;
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            istat_r <= RST_EVT;
        end else if (i_wr && i_addr == ADDR_ISTAT) begin
            istat_r <= (istat_r & ~i_wdata[3:0]) | evt;
        end else begin
            istat_r <= istat_r | evt;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            imask_r <= RST_EVT;
        end else if (i_wr && i_addr == ADDR_IMASK) begin
            imask_r <= i_wdata[3:0];
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(istat_r & imask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_TCTL:  o_rdata <= tctl_r;
                ADDR_TMODE: o_rdata <= tmode_r;
                ADDR_TL0:   o_rdata <= tl0_r;                    // [R16]
                ADDR_TL1:   o_rdata <= tl1_r;                    // [R16]
                ADDR_TH0:   o_rdata <= th0_r;                    // [R16]
                ADDR_TH1:   o_rdata <= th1_r;                    // [R16]
                ADDR_ISTAT: o_rdata <= {4'h0, istat_r};
                ADDR_IMASK: o_rdata <= {4'h0, imask_r};
                default:    o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    assign o_tctl = tctl_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    ovf_zero_flag_a: assert property (ovf0 |=> tctl_r.overflow_flag_zero) // [R2]
        else $error("timer zero overflow did not set its flag");
    ovf_one_flag_a: assert property (ovf1 |=> tctl_r.overflow_flag_one) // [R1]
        else $error("timer one overflow did not set its flag");
    run_zero_hold_a: assert property ( // [R4]
        (!tctl_r.run_bit_zero && !wr_tl0 && !th0_split_en)
        |=> tl0_r == $past(tl0_r))
        else $error("timer zero low byte moved while stopped");
    gate_one_hold_a: assert property ( // [R3]
        (tmode_r.one.gate && !smp_r.ext_irq_pin_one && !i_wr)
        |=> (tl1_r == $past(tl1_r)) && (th1_r == $past(th1_r)))
        else $error("gated timer one moved with pin low");
    split_one_stop_a: assert property ( // [R15]
        (tmode_r.one.mode == MODE_SPLIT && !i_wr)
        |=> $stable(tl1_r) && $stable(th1_r))
        else $error("timer one moved in mode 3");
    level_zero_track_a: assert property ( // [R6]
        (!tctl_r.ext_irq_type_zero && !wr_tctl) ##1
        !tctl_r.ext_irq_type_zero
        |-> tctl_r.ext_irq_flag_zero == !$past(smp_r.ext_irq_pin_zero))
        else $error("level irq zero flag does not follow pin");
    edge_one_ack_a: assert property ( // [R5]
        (tctl_r.ext_irq_type_one && i_ack.irq_one && !irq1_edge && !wr_tctl)
        |=> !tctl_r.ext_irq_flag_one)
        else $error("edge irq one flag not cleared by service");
    reload_eight_a: assert property ( // [R13]
        (cnt1_en && tmode_r.one.mode == MODE_RELD8 && tl1_r == 8'hff
         && !wr_tl1 && !wr_th1 && !split0)
        |=> tl1_r == th1_r && tctl_r.overflow_flag_one)
        else $error("mode 2 reload or flag missing");
    count_sixteen_a: assert property ( // [R12]
        (cnt0_en && tmode_r.zero.mode == MODE_CNT16 && !wr_tl0 && !wr_th0)
        |=> {th0_r, tl0_r} == $past({th0_r, tl0_r}) + 16'h0001)
        else $error("mode 1 did not advance by one");
    fall_sample_a: assert property ( // [R18]
        (mcyc && fall.count_input_zero) |=> !smp_r.count_input_zero)
        else $error("falling edge not followed by low sample");
    irq_out_a: assert property (
        (|(istat_r & imask_r)) |=> o_irq)
        else $error("unmasked status did not raise interrupt");

    split_run_c: cover property (th0_split_en && th0_s8[8]);
    edge_irq_c: cover property (irq0_edge ##[1:50] i_ack.irq_zero);
    prescale_ovf_c: cover property (
        ovf0 && tmode_r.zero.mode == MODE_PRE13);
    counter_mode_c: cover property (cnt1_en && tmode_r.one.count_sel);
endmodule : dtc_timer

// ==== sim/dtc_pin_model.sv ====
// Far-side model of the count and external interrupt pins
`timescale 1ns/1ns
module dtc_pin_model #(
    parameter int HOLD_CLKS = 4
) (
    input  wire logic               i_clock,
    input  wire logic               i_nrst,
    input  wire dtc_pkg::dtc_pins_t i_want,
    output dtc_pkg::dtc_pins_t      o_pins
);
    import dtc_pkg::*;
    int unsigned held;

    // A new level waits until the old one stood long enough to sample
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pins <= '1;
            held   <= 0;
        end else if (i_want != o_pins && held >= HOLD_CLKS) begin
            o_pins <= i_want;
            held   <= 0;
        end else begin
            held <= held + 1;
        end
    end
endmodule : dtc_pin_model

// ==== sim/dtc_timer_test.sv ====
// Self-checking bench for the dual timer block
`timescale 1ns/1ns
module dtc_timer_test;
    import dtc_pkg::*;
    localparam int MC = 2;
    logic       i_clock;
    logic       i_nrst;
    logic [7:0] i_addr;
    logic [7:0] i_wdata;
    logic       i_wr;
    logic       i_rd;
    dtc_pins_t  want;
    dtc_pins_t  pins;
    dtc_ack_t   i_ack;
    logic [7:0] o_rdata;
    dtc_tctl_t  o_tctl;
    logic       o_irq;
    logic [7:0] d;
    int         n_mismatch = 0;
    int         checks_done = 0;
    int         cycles = 0;

    dtc_pin_model #(.HOLD_CLKS(MC + 2)) dtc_pin_model_inst (
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .i_want  (want),
        .o_pins  (pins)
    );
    dtc_timer #(.MCYC_CLKS(MC)) dtc_timer_inst (
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .i_addr  (i_addr),
        .i_wdata (i_wdata),
        .i_wr    (i_wr),
        .i_rd    (i_rd),
        .i_pins  (pins),
        .i_ack   (i_ack),
        .o_rdata (o_rdata),
        .o_tctl  (o_tctl),
        .o_irq   (o_irq)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clock);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= v;
        @(posedge i_clock);
        i_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge i_clock);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask : rd

    task automatic ack(input int b);
        @(posedge i_clock);
        i_ack[b] <= 1'b1;
        @(posedge i_clock);
        i_ack <= '0;
        #1;
    endtask : ack

    task automatic pin(input int b, input logic v);
        want[b] <= v;
        repeat (14) @(posedge i_clock);
        #1;
    endtask : pin

    task automatic wait_bit(input int b);
        for (int k = 0; k < 60 && o_tctl[b] !== 1'b1; k++)
            @(posedge i_clock);
        #1;
    endtask : wait_bit

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    // Overflow in one mode, then hardware and software flag handling
    task automatic run_ovf(input int t, input logic [1:0] m);
        logic [7:0] th;
        logic [7:0] el;
        th = (m == MODE_RELD8) ? 8'ha5 : 8'hff;
        el = (m == MODE_PRE13) ? 8'he0 : (m == MODE_RELD8) ? 8'ha0 : 8'h00;
        wr(ADDR_TMODE, t ? {2'h0, m, 4'h0} : {6'h0, m});
        wr(ADDR_TL0 + 8'(t), 8'hff);
        wr(ADDR_TH0 + 8'(t), th);
        wr(ADDR_IMASK, 8'h04 << t);
        wr(ADDR_TCTL, 8'h10 << (2 * t));
        wait_bit(5 + 2 * t);
        wr(ADDR_TCTL, 8'h20 << (2 * t));
        check({7'h0, o_tctl[5 + 2 * t]}, 8'h01);
        check({7'h0, o_irq}, 8'h01);
        rd(ADDR_TH0 + 8'(t));
        check(d, (m == MODE_RELD8) ? 8'ha5 : 8'h00);
        rd(ADDR_TL0 + 8'(t));
        check(d & ((m == MODE_PRE13) ? 8'he0 : 8'hf0), el);
        rd(ADDR_ISTAT);
        check(d & (8'h04 << t), 8'h04 << t);
        ack(2 + t);
        check({7'h0, o_tctl[5 + 2 * t]}, 8'h00);
        wr(ADDR_TCTL, 8'h20 << (2 * t));
        check({7'h0, o_tctl[5 + 2 * t]}, 8'h01);
        wr(ADDR_ISTAT, 8'h0f);
        wr(ADDR_TCTL, 8'h00);
        check({7'h0, o_tctl[5 + 2 * t]}, 8'h00);
        check({7'h0, o_irq}, 8'h00);
    endtask : run_ovf

    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        i_nrst  = 1'b0;
        i_addr  = 8'h00;
        i_wdata = 8'h00;
        i_wr    = 1'b0;
        i_rd    = 1'b0;
        i_ack   = '0;
        want    = '1;
        repeat (10) @(posedge i_clock);
        i_nrst <= 1'b1;
        // Reset values, unmapped place, byte access
        for (int i = 0; i < 8; i++) begin
            rd((i < 6) ? ADDR_TCTL + 8'(i) : ADDR_ISTAT + 8'(i - 6));
            check(d, RST_BYTE);
        end
        wr(8'h80, 8'hff);
        rd(8'h80);
        check(d, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_TL0 + 8'(i), 8'h5a + 8'(i));
            rd(ADDR_TL0 + 8'(i));
            check(d, 8'h5a + 8'(i));
        end
        $display("test registers done");
        for (int t = 0; t < 2; t++) begin
            for (int m = 0; m < 3; m++) begin
                run_ovf(t, 2'(m));
            end
        end
        wr(ADDR_IMASK, 8'h00);
        $display("test overflow done");
        for (int t = 0; t < 2; t++) begin
            wr(ADDR_TMODE, t ? 8'h90 : 8'h09);
            wr(ADDR_TL0 + 8'(t), 8'h00);
            pin(t, 1'b0);
            wr(ADDR_TCTL, 8'h10 << (2 * t));
            repeat (20) @(posedge i_clock);
            rd(ADDR_TL0 + 8'(t));
            check(d, 8'h00);
            pin(t, 1'b1);
            rd(ADDR_TL0 + 8'(t));
            check({7'h0, d == 8'h00}, 8'h00);
            wr(ADDR_TCTL, 8'h00);
        end
        $display("test gating done");
        for (int t = 0; t < 2; t++) begin
            wr(ADDR_TMODE, t ? 8'h50 : 8'h05);
            wr(ADDR_TL0 + 8'(t), 8'h00);
            wr(ADDR_TCTL, 8'h10 << (2 * t));
            repeat (3) begin
                pin(2 + t, 1'b0);
                pin(2 + t, 1'b1);
            end
            wr(ADDR_TCTL, 8'h00);
            rd(ADDR_TL0 + 8'(t));
            check(d, 8'h03);
        end
        $display("test counter done");
        for (int t = 0; t < 2; t++) begin
            wr(ADDR_TCTL, 8'h01 << (2 * t));
            pin(t, 1'b0);
            check({7'h0, o_tctl[1 + 2 * t]}, 8'h01);
            pin(t, 1'b1);
            check({7'h0, o_tctl[1 + 2 * t]}, 8'h01);
            ack(t);
            check({7'h0, o_tctl[1 + 2 * t]}, 8'h00);
            wr(ADDR_TCTL, 8'h00);
            pin(t, 1'b0);
            check({7'h0, o_tctl[1 + 2 * t]}, 8'h01);
            pin(t, 1'b1);
            check({7'h0, o_tctl[1 + 2 * t]}, 8'h00);
        end
        $display("test external interrupts done");
        wr(ADDR_TMODE, 8'h33);
        wr(ADDR_TL0, 8'h00);
        wr(ADDR_TL1, 8'h55);
        wr(ADDR_TH0, 8'hff);
        wr(ADDR_TCTL, 8'h40);
        wait_bit(7);
        wr(ADDR_TCTL, 8'h80);
        check({7'h0, o_tctl.overflow_flag_one}, 8'h01);
        rd(ADDR_TL1);
        check(d, 8'h55);
        rd(ADDR_TL0);
        check(d, 8'h00);
        rd(ADDR_TH0);
        check(d & 8'hf0, 8'h00);
        wr(ADDR_TCTL, 8'h00);
        $display("test split mode done");
        summarize();
    end
endmodule : dtc_timer_test
